/* File: verilog/bwa_consts.vh */
// Purpose: shared constants of the bus width adapter
// Assumes: included by bare name from each design file
// Notes:   definitions only
`ifndef BWA_CONSTS_VH
`define BWA_CONSTS_VH

// alignment style codes on the align_dyn input
`define BWA_ALIGN_NATIVE  1'b0
`define BWA_ALIGN_DYNAMIC 1'b1

// reset values
`define BWA_MERGE_RST     1'b0
`define BWA_BEAT_RST      8'h00

// width of the internal scratch address
`define BWA_XADDR_W       64

`endif

/* File: verilog/bwa_merge_reg.v */
// Purpose: merge register that collects narrow read words into one wide word
// Assumes: MW is a whole multiple of SW
// Notes:   read data come straight from the register
`include "bwa_consts.vh"
`default_nettype none

module bwa_merge_reg #(
    parameter MW = 32,
    parameter SW = 16
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire          wr_en,
    input  wire [7:0]    idx,
    input  wire [SW-1:0] din,
    output wire [MW-1:0] dout
);
    reg [MW-1:0] merge_q;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            merge_q <= {MW{`BWA_MERGE_RST}};
        end else if (wr_en) begin
            merge_q[idx*SW +: SW] <= din;
        end
    end

    assign dout = merge_q;
endmodule // bwa_merge_reg

`default_nettype wire

/* File: verilog/bwa_adapter.v */
// Purpose: width adapter between one master port and one slave port
// Assumes: no-latency slave handshake, master holds its request until wait drops
// Notes:   align_dyn is a static style select driven by same-clock fabric logic
`include "bwa_consts.vh"
`default_nettype none

module bwa_adapter #(
    parameter MW  = 32,
    parameter SW  = 16,
    parameter MAW = 30,
    parameter SAW = 32
) (
    input  wire            ref_clk,
    input  wire            rst,
    input  wire            align_dyn,
    input  wire [MAW-1:0]  m_addr,
    input  wire            m_read,
    input  wire            m_write,
    input  wire [MW-1:0]   m_wdata,
    input  wire [MW/8-1:0] m_be,
    output reg  [MW-1:0]   m_rdata,
    output reg             m_waitreq,
    output reg  [SAW-1:0]  s_addr,
    output reg             s_read,
    output reg             s_write,
    output reg  [SW-1:0]   s_wdata,
    output reg  [SW/8-1:0] s_be,
    input  wire [SW-1:0]   s_rdata,
    input  wire            s_waitreq
);
    localparam MBE = MW / 8;
    localparam SBE = SW / 8;
    localparam XW  = `BWA_XADDR_W;

    function integer bwa_log2;
        input integer v;
        integer k;
        begin
            bwa_log2 = 0;
            for (k = 1; k < v; k = k * 2) begin
                bwa_log2 = bwa_log2 + 1;
            end
        end
    endfunction

    wire [XW-1:0] m_addr_x = {{(XW-MAW){1'b0}}, m_addr};
    wire          m_req    = m_read | m_write;

    // native path
    reg [SAW-1:0] nat_addr;
    reg [SW-1:0]  nat_wdata;
    reg [SBE-1:0] nat_be;
    reg [MW-1:0]  nat_rdata;
    // dynamic path
    wire [SAW-1:0] dyn_addr;
    wire           dyn_read;
    wire           dyn_write;
    wire [SW-1:0]  dyn_wdata;
    wire [SBE-1:0] dyn_be;
    wire [MW-1:0]  dyn_rdata;
    wire           dyn_wait;

    // native wiring, one offset per word
    generate
        if (MW >= SW) begin : g_nat_fill
            always @* begin
                nat_addr  = m_addr_x[SAW-1:0];
                nat_rdata = {MW{1'b0}};
                nat_rdata[SW-1:0] = s_rdata;
                nat_wdata = m_wdata[SW-1:0];
                nat_be    = m_be[SBE-1:0];
            end
        end else begin : g_nat_low
            always @* begin
                nat_addr  = m_addr_x[SAW-1:0];
                nat_rdata = s_rdata[MW-1:0];
                nat_wdata = {SW{1'b0}};
                nat_wdata[MW-1:0] = m_wdata;
                nat_be    = {SBE{1'b0}};
                nat_be[MBE-1:0] = m_be;
            end
        end
    endgenerate

    generate
        if (MW > SW) begin : g_wide
            localparam integer RATIO = MW / SW;
            localparam RB    = bwa_log2(RATIO);
            localparam [1:0] ST_IDLE = 2'h0;
            localparam [1:0] ST_RUN  = 2'h1;
            localparam [1:0] ST_DONE = 2'h2;
            localparam [7:0] NONE    = RATIO[7:0];

            reg [1:0] state_q;
            reg [1:0] state_d;
            reg [7:0] beat_q;
            reg [7:0] beat_d;
            reg [XW-1:0] addr_x;

            // lowest beat at or after 'from' that must be issued
            function [7:0] next_beat;
                input [7:0]     from;
                input [MBE-1:0] be;
                input           rd;
                integer i;
                begin
                    next_beat = NONE;
                    for (i = RATIO - 1; i >= 0; i = i - 1) begin
                        if (i >= from && (rd || (|be[i*SBE +: SBE]))) begin
                            next_beat = i[7:0];
                        end
                    end
                end
            endfunction

            wire       beat_ok = (state_q == ST_RUN) && !s_waitreq;
            wire [7:0] first   = next_beat(8'h00, m_be, m_read);
            wire [7:0] after   = next_beat(beat_q + 8'h01, m_be, m_read);

            // master keeps a full-width request steady while waiting
            always @* begin
                state_d = state_q;
                beat_d  = beat_q;
                case (state_q)
                    ST_IDLE: begin
                        if (m_req && align_dyn == `BWA_ALIGN_DYNAMIC) begin
                            if (first == NONE) begin
                                state_d = ST_DONE;
                            end else begin
                                beat_d  = first;
                                state_d = ST_RUN;
                            end
                        end
                    end
                    ST_RUN: begin
                        if (!s_waitreq) begin
                            if (after == NONE) begin
                                state_d = ST_DONE;
                            end else begin
                                beat_d = after;
                            end
                        end
                    end
                    ST_DONE: begin
                        state_d = ST_IDLE;
                    end
                    default: begin
                        state_d = ST_IDLE;
                    end
                endcase
            end

            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    state_q <= ST_IDLE;
                    beat_q  <= `BWA_BEAT_RST;
                end else begin
                    state_q <= state_d;
                    beat_q  <= beat_d;
                end
            end

            always @* begin
                addr_x = (m_addr_x << RB) | {{(XW-8){1'b0}}, beat_q};
            end

            assign dyn_addr  = addr_x[SAW-1:0];
            assign dyn_read  = (state_q == ST_RUN) && m_read;
            assign dyn_write = (state_q == ST_RUN) && m_write;
            assign dyn_wdata = m_wdata[beat_q*SW +: SW];
            assign dyn_be    = m_read ? {SBE{1'b1}} : m_be[beat_q*SBE +: SBE];
            assign dyn_wait  = m_req && (state_q != ST_DONE);

            // merge each narrow word into its lanes
            bwa_merge_reg #(
                .MW (MW),
                .SW (SW)
            ) u_merge (
                .ref_clk (ref_clk),
                .rst     (rst),
                .wr_en   (beat_ok && m_read),
                .idx     (beat_q),
                .din     (s_rdata),
                .dout    (dyn_rdata)
            );
        end else if (MW < SW) begin : g_narrow
            localparam RATIO = SW / MW;
            localparam RB    = bwa_log2(RATIO);

            reg [SBE-1:0] be_sel;
            reg [XW-1:0]  addr_x;
            wire [7:0]    sel = {{(8-RB){1'b0}}, m_addr[RB-1:0]};

            // several master words share one offset
            always @* begin
                addr_x = m_addr_x >> RB;
                be_sel = {SBE{1'b0}};
                be_sel[sel*MBE +: MBE] = m_be;
            end

            assign dyn_addr  = addr_x[SAW-1:0];
            assign dyn_read  = m_read;
            assign dyn_write = m_write;
            assign dyn_wdata = {RATIO{m_wdata}};
            assign dyn_be    = be_sel;
            assign dyn_rdata = s_rdata[sel*MW +: MW];
            assign dyn_wait  = s_waitreq;
        end else begin : g_equal
            assign dyn_addr  = nat_addr;
            assign dyn_read  = m_read;
            assign dyn_write = m_write;
            assign dyn_wdata = nat_wdata;
            assign dyn_be    = nat_be;
            assign dyn_rdata = nat_rdata;
            assign dyn_wait  = s_waitreq;
        end
    endgenerate

    always @* begin
        if (align_dyn == `BWA_ALIGN_DYNAMIC) begin
            s_addr    = dyn_addr;
            s_read    = dyn_read;
            s_write   = dyn_write;
            s_wdata   = dyn_wdata;
            s_be      = dyn_be;
            m_rdata   = dyn_rdata;
            m_waitreq = dyn_wait;
        end else begin
            s_addr    = nat_addr;
            s_read    = m_read;
            s_write   = m_write;
            s_wdata   = nat_wdata;
            s_be      = nat_be;
            m_rdata   = nat_rdata;
            m_waitreq = s_waitreq;
        end
    end
endmodule // bwa_adapter

`default_nettype wire

/* File: sim/bwa_slave_model.sv */
// Purpose: 16-bit slave memory facing the adapter
// Assumes: offsets below 16
// Notes:   slow mode stalls the first cycle of each slave request
`default_nettype none
module bwa_slave_model (
    input  wire logic        ref_clk,
    input  wire logic        slow,
    input  wire logic [31:0] s_addr,
    input  wire logic        s_read,
    input  wire logic        s_write,
    input  wire logic [15:0] s_wdata,
    input  wire logic [1:0]  s_be,
    output logic      [15:0] s_rdata,
    output logic             s_waitreq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:15];
    logic [15:0] last_q = 16'h0000;
    logic        held_q = 1'b0;
    assign s_waitreq = slow && (s_read || s_write) && !held_q;
    // unselected bus shows the inverse of the last word
    assign s_rdata = s_read ? mem[s_addr[3:0]] : ~last_q;
    always @(posedge ref_clk) begin
        held_q <= s_waitreq;
        if (s_read && !s_waitreq) last_q <= mem[s_addr[3:0]];
        if (s_write && !s_waitreq && s_be[0]) mem[s_addr[3:0]][7:0] <= s_wdata[7:0];
        if (s_write && !s_waitreq && s_be[1]) mem[s_addr[3:0]][15:8] <= s_wdata[15:8];
    end
endmodule // bwa_slave_model
`default_nettype wire

/* File: sim/bwa_adapter_props.sv */
// Purpose: port checker of the width adapter
// Assumes: align_dyn static during a transfer, ratio two in dynamic mode
// Notes:   bound into every adapter instance
`default_nettype none
module bwa_adapter_props #(parameter MW = 32, parameter SW = 16, parameter MAW = 30, parameter SAW = 32) (
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic            align_dyn,
    input wire logic [MAW-1:0]  m_addr,
    input wire logic            m_read,
    input wire logic            m_write,
    input wire logic [MW/8-1:0] m_be,
    input wire logic [MW-1:0]   m_rdata,
    input wire logic            m_waitreq,
    input wire logic [SAW-1:0]  s_addr,
    input wire logic            s_read,
    input wire logic            s_write,
    input wire logic [SW/8-1:0] s_be,
    input wire logic [SW-1:0]   s_rdata,
    input wire logic            s_waitreq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_native_pass: assert property (!align_dyn |-> m_waitreq == s_waitreq && s_read == m_read && s_write == m_write)
        else $error("native request not passed");
    a_native_addr: assert property (!align_dyn |-> s_addr == SAW'(m_addr))
        else $error("native offset wrong");
    a_native_fill: assert property (!align_dyn |-> m_rdata == MW'(s_rdata))
        else $error("native read data wrong");
    a_wide_hold: assert property (align_dyn && $rose(m_read) |-> m_waitreq [*3])
        else $error("wide read released early");
    a_wide_rd_be: assert property (align_dyn && s_read |-> s_be == {(SW/8){1'b1}})
        else $error("wide read lanes wrong");
    a_wide_asc: assert property (align_dyn && s_read && !s_waitreq ##1 s_read |-> s_addr == $past(s_addr) + 1)
        else $error("wide beats not ascending");
    a_wide_merge: assert property (align_dyn && m_read && !m_waitreq |->
        $past(s_read) && $past(s_addr[0]) && m_rdata[MW-1:SW] == $past(s_rdata))
        else $error("wide merge wrong");
    a_wide_wr_be: assert property (align_dyn && s_write |->
        s_be != 0 && s_be == m_be[(s_addr % (MW/SW))*(SW/8) +: SW/8])
        else $error("wide write lanes wrong");
endmodule // bwa_adapter_props
bind bwa_adapter bwa_adapter_props #(.MW(MW), .SW(SW), .MAW(MAW), .SAW(SAW)) i_props (
    .ref_clk(ref_clk), .rst(rst), .align_dyn(align_dyn), .m_addr(m_addr), .m_read(m_read),
    .m_write(m_write), .m_be(m_be), .m_rdata(m_rdata), .m_waitreq(m_waitreq), .s_addr(s_addr),
    .s_read(s_read), .s_write(s_write), .s_be(s_be), .s_rdata(s_rdata), .s_waitreq(s_waitreq));
`default_nettype wire

/* File: sim/bwa_adapter_tb_top.sv */
// Purpose: self-checking bench of the width adapter, 32-bit master on 16-bit slave
// Assumes: inputs change at the falling edge
// Notes:   native reads cross-check what dynamic writes placed
`default_nettype none
module bwa_adapter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst = 1'b1, align_dyn = 1'b0, slow = 1'b0, m_read = 1'b0, m_write = 1'b0;
    logic [29:0] m_addr = 30'h0;
    logic [31:0] m_wdata = 32'h0, m_rdata, s_addr, q;
    logic [3:0]  m_be = 4'h0;
    logic [15:0] s_wdata, s_rdata;
    logic [1:0]  s_be;
    logic        m_waitreq, s_read, s_write, s_waitreq;
    int          n_errors = 0;
    int          comparisons = 0;
    initial forever #25 ref_clk = ~ref_clk;
    bwa_adapter i_dut (.ref_clk(ref_clk), .rst(rst), .align_dyn(align_dyn), .m_addr(m_addr), .m_read(m_read),
        .m_write(m_write), .m_wdata(m_wdata), .m_be(m_be), .m_rdata(m_rdata), .m_waitreq(m_waitreq),
        .s_addr(s_addr), .s_read(s_read), .s_write(s_write), .s_wdata(s_wdata), .s_be(s_be),
        .s_rdata(s_rdata), .s_waitreq(s_waitreq));
    bwa_slave_model i_slave (.ref_clk(ref_clk), .slow(slow), .s_addr(s_addr), .s_read(s_read),
        .s_write(s_write), .s_wdata(s_wdata), .s_be(s_be), .s_rdata(s_rdata), .s_waitreq(s_waitreq));
    task results;
        if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task txn(input logic rd, input logic [29:0] a, input logic [31:0] d, input logic [3:0] be);
        int i;
        @(negedge ref_clk);
        {m_read, m_write, m_addr, m_wdata, m_be} = {rd, !rd, a, d, be};
        #1;
        for (i = 0; i < 20 && m_waitreq !== 1'b0; i++) begin
            @(negedge ref_clk);
            #1;
        end
        if (m_waitreq !== 1'b0) begin
            n_errors++;
            $display("[ERR] %0t wait never released", $time);
            results();
        end
        q = m_rdata;
        @(negedge ref_clk);
        {m_read, m_write} = 2'b00;
    endtask
    task t_native;
        align_dyn = 1'b0;
        txn(1'b0, 30'h3, 32'hA5A5_1234, 4'hF);
        txn(1'b1, 30'h3, 32'h0, 4'hF);
        chk(q, 32'h0000_1234);
    endtask
    task t_wide;
        align_dyn = 1'b1;
        txn(1'b0, 30'h1, 32'hCAFE_BEEF, 4'hF);
        txn(1'b1, 30'h1, 32'h0, 4'hF);
        chk(q, 32'hCAFE_BEEF);
        align_dyn = 1'b0;
        txn(1'b1, 30'h2, 32'h0, 4'hF);
        chk(q, 32'h0000_BEEF);
        txn(1'b1, 30'h3, 32'h0, 4'hF);
        chk(q, 32'h0000_CAFE);
    endtask
    task t_wide_be;
        align_dyn = 1'b1;
        txn(1'b0, 30'h1, 32'h1111_2222, 4'hC);
        txn(1'b0, 30'h1, 32'h3333_4444, 4'h0);
        txn(1'b0, 30'h1, 32'h6666_7755, 4'h1);
        txn(1'b1, 30'h1, 32'h0, 4'hF);
        chk(q, 32'h1111_BE55);
    endtask
    task t_slow;
        slow = 1'b1;
        txn(1'b1, 30'h1, 32'h0, 4'hF);
        chk(q, 32'h1111_BE55);
        align_dyn = 1'b0;
        txn(1'b1, 30'h3, 32'h0, 4'hF);
        chk(q, 32'h0000_1111);
        slow = 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        t_native();
        t_wide();
        t_wide_be();
        t_slow();
        results();
    end
endmodule // bwa_adapter_tb_top
`default_nettype wire
